// File: rtl/supervisor_cfg.svh
// Constants for the supervisor fault configuration and log block
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH
`define CMD_CFG_FIRST 8'h0a
`define CMD_CFG_LAST 8'h0f
`define CMD_HISTORY 8'h11
`define CMD_PADS 8'h1a
`define CMD_CLEAR 8'h1b
`define CMD_STORE 8'h1c
`define CMD_RESTORE 8'h1d
`define CMD_BACKUP 8'h1e
`define CFG_HOLD 12
`define CFG_HI_OUT 11
`define CFG_LO_OUT 10
`define CFG_SCALE_HI 9
`define CFG_SCALE_LO 8
`define CFG_HI_SENSE 7
`define CFG_LO_SENSE 6
`define CFG_HI_PIN3 5
`define CFG_LO_PIN3 2
`define CFG_USED_MASK 16'h1fff
`define HIST_USED_MASK 16'h1ffe
`define PADS_USED_MASK 16'h07ff
`define CFG_RESET_A 16'h0c89
`define CFG_RESET_B 16'h0d89
`define CLK_HZ 50000000
`define CLEAR_TIME_MS 10
`define CLEAR_CYCLES (`CLEAR_TIME_MS * (`CLK_HZ / 1000))
`define LOAD_TIME_US 200
`define LOAD_CYCLES (`LOAD_TIME_US * (`CLK_HZ / 1000000))
`endif

// File: rtl/supervisor_fault_config_log.sv
// Channel configuration, fault history, pad readback and EEPROM backup
//
// Functional notes
// - Hold bit chooses follow (0) or latched (1) channel fault output.
// - High or low fault reaches channel output only when its map bit set.
// - Scale field: 00 medium, 01 low, 10 or 11 precision.
// - Sense bit 0 means below threshold faults, 1 means above.
// - Three bits route the high fault to general pins 3, 2, 1.
// - Three bits route the low fault to general pins 3, 2, 1.
// - History command read returns faults since power-up or last clear.
// - History bits set automatically on fault and stay until cleared.
// - History: channel n high at 2n, low at 2n-1, rest zero.
// - Clear command zeroes every history bit except those of faults still present.
// - Manual reset input clears history when its option bit is set.
// - Clearing history leaves live comparator status untouched.
// - During clear processing no other bus request is acknowledged.
// - Pad command read returns present sampled pin levels.
// - Pads: 10 input2, 9 input1, 8..6 io pins, 5..0 channel outputs.
// - Store copies configuration to EEPROM; restore and power-up reload.
// - First fault writes history copy into backup location.
// - Further backup writes blocked until a clear re-arms them.
// - Channel configuration words at commands 0x0a to 0x0f.
// - Latched alert released by alert address ack, history read, clear.
// - At power-up EEPROM contents load into working memory.
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
module supervisor_fault_config_log #(
  parameter int unsigned CLEAR_CYCLES = `CLEAR_CYCLES,
  parameter int unsigned LOAD_CYCLES = `LOAD_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command port from the serial front end
  input supervisor_pkg::cmd_req_t cmd_req,
  input wire logic alert_ack,
  output supervisor_pkg::cmd_rsp_t cmd_rsp,
  // Raw comparator levels, high at input above threshold
  input wire logic [5:0] above_hi,
  input wire logic [5:0] above_lo,
  // General inputs and pins
  input wire logic [1:0] general_input_pin,
  input wire logic [1:0] manual_reset_input_en,
  input wire logic [1:0] manual_reset_wipes_log,
  input wire logic [2:0] general_io_pin,
  input wire logic [5:0] chan_fault_pad,
  // Outputs
  output logic [5:0] chan_fault_out,
  output logic [2:0] pin_fault_route,
  output logic alert_latched,
  output logic [11:0] chan_scale_select,
  output logic [5:0] upper_comparator,
  output logic [5:0] lower_comparator
);
  import supervisor_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    phase_t phase;
    logic [22:0] cnt;
    logic [5:0][15:0] cfg;
    logic [5:0][15:0] nv_cfg;
    logic [15:0] hist;
    logic [15:0] backup;
    logic [15:0] nv_backup;
    logic backup_done;
    logic [5:0] hold;
    logic alert;
    logic [5:0] chan_out;
    logic [2:0] pin_out;
    logic [5:0] up;
    logic [5:0] lo;
    logic [11:0] scale;
    cmd_rsp_t rsp;
    logic [12:0] s1;
    logic [12:0] s2;
    logic [5:0] hs1;
    logic [5:0] hs2;
    logic [5:0] ls1;
    logic [5:0] ls2;
  } state_t;

  state_t q, d;
  logic [5:0] f_hi, f_lo, map_act;
  logic [2:0] route;
  logic [15:0] hist_now, pads, rd;
  logic mr_clear, ev_fault;
  logic [2:0] cidx;

  // ****************************************************************
  // Per-channel fault logic
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_ch
      // Sense selects over- or undervoltage meaning
      assign f_hi[gi] = q.cfg[gi][`CFG_HI_SENSE] ? q.hs2[gi]
                                                 : ~q.hs2[gi];
      assign f_lo[gi] = q.cfg[gi][`CFG_LO_SENSE] ? q.ls2[gi]
                                                 : ~q.ls2[gi];
      assign map_act[gi] = (f_hi[gi] & q.cfg[gi][`CFG_HI_OUT]) |
                           (f_lo[gi] & q.cfg[gi][`CFG_LO_OUT]);
    end
  endgenerate

  always_comb begin
    route = 3'h0;
    for (int i = 0; i < 6; i++) begin
      route = route |
        (q.cfg[i][`CFG_HI_PIN3 -: 3] & {3{f_hi[i]}}) |
        (q.cfg[i][`CFG_LO_PIN3 -: 3] & {3{f_lo[i]}});
    end
  end

  always_comb begin
    hist_now = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      hist_now[2 * i + 2] = f_hi[i];
      hist_now[2 * i + 1] = f_lo[i];
    end
  end

  // Manual reset is active low and sampled through two flops first
  assign mr_clear = |(manual_reset_input_en & manual_reset_wipes_log &
                      ~q.s2[12:11]);
  assign pads = {5'h00, q.s2[10:0]} & `PADS_USED_MASK;
  assign ev_fault = |hist_now;
  assign cidx = 3'(cmd_req.cmd - `CMD_CFG_FIRST);

  always_comb begin
    case (cmd_req.cmd)
      `CMD_HISTORY: rd = q.hist & `HIST_USED_MASK;
      `CMD_PADS: rd = pads;
      `CMD_BACKUP: rd = q.backup;
      default: begin
        if (cmd_req.cmd >= `CMD_CFG_FIRST && cmd_req.cmd <= `CMD_CFG_LAST)
          rd = q.cfg[cidx] & `CFG_USED_MASK;
        else
          rd = 16'h0000;
      end
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    d.s1 = {general_input_pin, general_input_pin, general_io_pin,
            chan_fault_pad};
    d.s2 = q.s1;
    // Comparators switch with no regard to clk, so two flops first
    d.hs1 = above_hi;
    d.hs2 = q.hs1;
    d.ls1 = above_lo;
    d.ls2 = q.ls1;
    d.rsp.ack = 1'b0;
    d.rsp.busy = (q.phase != ST_RUN);
    case (q.phase)
      ST_LOAD: begin
        d.cnt = q.cnt + 23'h1;
        if (q.cnt >= 23'(LOAD_CYCLES - 1)) begin
          d.cfg = q.nv_cfg;
          d.backup = q.nv_backup;
          d.phase = ST_RUN;
          d.cnt = 23'h0;
        end
      end
      ST_RUN: begin
        // Set wins: new faults OR in on every run cycle, clear only removes old bits
        d.hist = q.hist | (hist_now & `HIST_USED_MASK);
        if (ev_fault && !q.backup_done) begin
          d.nv_backup = d.hist;
          d.backup_done = 1'b1;
        end
        if (cmd_req.req) begin
          d.rsp.ack = 1'b1;
          d.rsp.rdata = rd;
          if (cmd_req.wr) begin
            if (cmd_req.cmd >= `CMD_CFG_FIRST &&
                cmd_req.cmd <= `CMD_CFG_LAST)
              d.cfg[cidx] = cmd_req.wdata & `CFG_USED_MASK;
            case (cmd_req.cmd)
              `CMD_CLEAR: begin
                d.phase = ST_CLEAR;
                d.cnt = 23'h0;
              end
              `CMD_STORE: begin
                d.nv_cfg = q.cfg;
                // A re-armed snapshot is overwritten, which erases it
                if (!q.backup_done)
                  d.nv_backup = q.hist & `HIST_USED_MASK;
              end
              `CMD_RESTORE: begin
                d.cfg = q.nv_cfg;
                d.backup = q.nv_backup;
              end
              default: ;
            endcase
          end else if (cmd_req.cmd == `CMD_HISTORY) begin
            d.alert = 1'b0;
          end
        end
        if (mr_clear) begin
          d.hist = hist_now & `HIST_USED_MASK;
          d.backup_done = 1'b0;
          d.hold = 6'h00;
        end
      end
      ST_CLEAR: begin
        d.rsp.busy = 1'b1;
        d.cnt = q.cnt + 23'h1;
        if (q.cnt >= 23'(CLEAR_CYCLES - 1)) begin
          // Present faults re-log at once so no fault still active at the end is dropped
          d.hist = hist_now & `HIST_USED_MASK;
          d.backup_done = 1'b0;
          d.hold = 6'h00;
          d.alert = 1'b0;
          d.phase = ST_RUN;
          d.cnt = 23'h0;
        end
      end
      default: d.phase = ST_LOAD;
    endcase
    for (int i = 0; i < 6; i++) begin
      if (map_act[i])
        d.hold[i] = 1'b1;
      d.chan_out[i] = q.cfg[i][`CFG_HOLD] ? (q.hold[i] | map_act[i])
                                          : map_act[i];
      d.scale[2 * i +: 2] = q.cfg[i][`CFG_SCALE_HI:`CFG_SCALE_LO];
    end
    if (alert_ack)
      d.alert = 1'b0;
    if (ev_fault && q.phase == ST_RUN)
      d.alert = 1'b1;
    d.pin_out = route;
    d.up = f_hi;
    d.lo = f_lo;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.phase <= ST_LOAD;
      q.rsp.busy <= 1'b1;
      for (int i = 0; i < 6; i++) begin
        q.nv_cfg[i] <= (i < 3) ? `CFG_RESET_A : `CFG_RESET_B;
      end
    end else begin
      q <= d;
    end
  end

  assign cmd_rsp = q.rsp;
  assign chan_fault_out = q.chan_out;
  assign pin_fault_route = q.pin_out;
  assign alert_latched = q.alert;
  assign chan_scale_select = q.scale;
  assign upper_comparator = q.up;
  assign lower_comparator = q.lo;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_no_ack_clear: assert property (@(posedge clk) disable iff (!rst_n)
    q.phase == ST_CLEAR |-> ##1 !cmd_rsp.ack)
    else $error("ack during clear");
  a_hist_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    q.phase == ST_RUN && d.phase == ST_RUN && !mr_clear
    |=> (q.hist & $past(q.hist)) == $past(q.hist))
    else $error("history bit lost");
  a_hist_resv: assert property (@(posedge clk) disable iff (!rst_n)
    (q.hist & ~`HIST_USED_MASK) == 16'h0000)
    else $error("reserved history bit set");
  a_clear_done: assert property (@(posedge clk) disable iff (!rst_n)
    q.phase == ST_CLEAR && d.phase == ST_RUN
    |=> q.hist == ($past(hist_now) & `HIST_USED_MASK))
    else $error("clear left stale bits");
  a_cfg_resv: assert property (@(posedge clk) disable iff (!rst_n)
    (q.cfg[0] & ~`CFG_USED_MASK) == 16'h0000)
    else $error("reserved config bit set");
  a_chan_follow: assert property (@(posedge clk) disable iff (!rst_n)
    !q.cfg[0][`CFG_HOLD] |=> chan_fault_out[0] == $past(map_act[0]))
    else $error("channel output mismatch");
  a_backup_once: assert property (@(posedge clk) disable iff (!rst_n)
    q.backup_done && q.phase == ST_RUN && !mr_clear
    |=> $stable(q.nv_backup))
    else $error("second backup write");
  a_pads_read: assert property (@(posedge clk) disable iff (!rst_n)
    q.phase == ST_RUN && cmd_req.req && !cmd_req.wr &&
    cmd_req.cmd == `CMD_PADS |=> cmd_rsp.rdata == $past(pads))
    else $error("pad readback wrong");
  a_busy_idle: assert property (@(posedge clk) disable iff (!rst_n)
    q.phase != ST_RUN |=> cmd_rsp.busy)
    else $error("busy low outside run");
  a_hist_read: assert property (@(posedge clk) disable iff (!rst_n)
    q.phase == ST_RUN && cmd_req.req && !cmd_req.wr &&
    cmd_req.cmd == `CMD_HISTORY
    |=> cmd_rsp.rdata == ($past(q.hist) & `HIST_USED_MASK))
    else $error("history readback wrong");
  a_nv_store: assert property (@(posedge clk) disable iff (!rst_n)
    q.phase == ST_RUN && cmd_req.req && cmd_req.wr &&
    cmd_req.cmd == `CMD_STORE |=> q.nv_cfg == $past(q.cfg))
    else $error("store lost configuration");
  a_load_end: assert property (@(posedge clk) disable iff (!rst_n)
    q.phase == ST_LOAD && d.phase == ST_RUN
    |=> q.cfg == $past(q.nv_cfg))
    else $error("power-up load wrong");
  a_alert_ack: assert property (@(posedge clk) disable iff (!rst_n)
    alert_ack && !(ev_fault && q.phase == ST_RUN)
    |=> !alert_latched)
    else $error("alert kept after ack");
  a_hold_keep: assert property (@(posedge clk) disable iff (!rst_n)
    q.cfg[0][`CFG_HOLD] && q.hold[0] |=> chan_fault_out[0])
    else $error("held output dropped");
  a_mr_wipe: assert property (@(posedge clk) disable iff (!rst_n)
    q.phase == ST_RUN && d.phase == ST_RUN && mr_clear
    |=> q.hist == ($past(hist_now) & `HIST_USED_MASK))
    else $error("manual reset left history");
  // Every channel word, not only the first, keeps its reserved bits clear
  generate
    for (gi = 0; gi < 6; gi++) begin : g_chk
      a_cfg_word_resv: assert property (@(posedge clk) disable iff (!rst_n)
        (q.cfg[gi] & ~`CFG_USED_MASK) == 16'h0000)
        else $error("reserved channel bit set");
    end
  endgenerate
  c_hold: cover property (@(posedge clk)
    q.cfg[0][`CFG_HOLD] && q.hold[0] && !map_act[0]);
  c_clear: cover property (@(posedge clk) q.phase == ST_CLEAR);
  c_backup: cover property (@(posedge clk) $rose(q.backup_done));
  c_alert: cover property (@(posedge clk) $fell(alert_latched));
endmodule : supervisor_fault_config_log

// File: rtl/supervisor_pkg.sv
// Types for the supervisor fault configuration and log block
package supervisor_pkg;
  typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_CLEAR} phase_t;
  typedef struct packed {
    logic req;
    logic wr;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } cmd_req_t;
  typedef struct packed {
    logic ack;
    logic busy;
    logic [15:0] rdata;
  } cmd_rsp_t;
endpackage : supervisor_pkg

// File: verification/host_model.sv
// Host side model that issues command words to the block
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
module host_model (
  // Clock
  input wire logic clk,
  // Answer from the block
  input supervisor_pkg::cmd_rsp_t rsp,
  // Request to the block
  output supervisor_pkg::cmd_req_t req
);
  import supervisor_pkg::*;
  initial req = '0;
  // ****************
  // Transfers
  // ****************
  // A refused request is simply sent again once busy has fallen
  task automatic xfer(input logic wr, input logic [7:0] c,
                      input logic [15:0] wd, output logic [15:0] rd);
    bit done;
    done = 0;
    for (int t = 0; t < 8 && !done; t++) begin
      for (int w = 0; w < 100 && rsp.busy !== 1'b0; w++) begin
        @(posedge clk);
        #1;
      end
      @(posedge clk);
      req <= '{1'b1, wr, c, wd};
      @(posedge clk);
      req.req <= 1'b0;
      #1;
      done = (rsp.ack === 1'b1);
    end
    rd = rsp.rdata;
  endtask : xfer
  task automatic read_snapshot(output logic [15:0] rd);
    xfer(1'b1, `CMD_RESTORE, 16'h0000, rd);
    xfer(1'b0, `CMD_BACKUP, 16'h0000, rd);
  endtask : read_snapshot
endmodule : host_model

// File: verification/testbench.sv
// Self-checking bench for the supervisor configuration and log block
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
module testbench;
  import supervisor_pkg::*;
  localparam int unsigned CLR = 20;
  logic clk = 0, rst_n = 0, alert_ack = 0, alert_latched;
  cmd_req_t cmd_req;
  cmd_rsp_t cmd_rsp;
  logic [5:0] above_hi = 0, above_lo = '1, chan_fault_pad = 0, r, l;
  logic [5:0] chan_fault_out, upper_comparator, lower_comparator;
  logic [1:0] general_input_pin = '1, manual_reset_input_en = 0;
  logic [1:0] manual_reset_wipes_log = 0;
  logic [2:0] general_io_pin = 0, pin_fault_route;
  logic [11:0] chan_scale_select;
  logic [15:0] cfg [6];
  logic [15:0] rd, hist, w;
  logic [31:0] seed = 32'd45268;
  int mismatches = 0, checks = 0, cyc = 0, n;
  always #10 clk = ~clk;
  supervisor_fault_config_log #(.CLEAR_CYCLES(CLR), .LOAD_CYCLES(4)) dut (
    .clk, .rst_n, .cmd_req, .alert_ack, .cmd_rsp, .above_hi, .above_lo,
    .general_input_pin, .manual_reset_input_en, .manual_reset_wipes_log,
    .general_io_pin, .chan_fault_pad, .chan_fault_out, .pin_fault_route,
    .alert_latched, .chan_scale_select, .upper_comparator,
    .lower_comparator);
  host_model host (.clk, .rsp(cmd_rsp), .req(cmd_req));
  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [5:0] flt(input logic [5:0] a, input int b);
    for (int i = 0; i < 6; i++) flt[i] = cfg[i][b] ? a[i] : ~a[i];
  endfunction : flt
  function automatic logic [15:0] hv(input logic [5:0] h, lo);
    hv = 16'h0000;
    for (int i = 0; i < 6; i++) hv[2*i+1 +: 2] = {h[i], lo[i]};
  endfunction : hv
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rdx(input logic [7:0] c, input logic [15:0] e);
    host.xfer(1'b0, c, 16'h0000, rd);
    check(rd, e);
  endtask : rdx
  task automatic drive(input logic [5:0] h, lo);
    @(posedge clk);
    above_hi <= h;
    above_lo <= lo;
    repeat (4) @(posedge clk);
    #1;
  endtask : drive
  task automatic defaults();
    for (int i = 0; i < 6; i++) begin
      cfg[i] = i < 3 ? `CFG_RESET_A : `CFG_RESET_B;
      rdx(`CMD_CFG_FIRST + 8'(i), cfg[i]);
    end
  endtask : defaults
  task automatic check_outs();
    logic [5:0] h, lo, c;
    logic [2:0] p;
    h = flt(above_hi, 7);
    lo = flt(above_lo, 6);
    c = 0;
    p = 0;
    for (int i = 0; i < 6; i++) begin
      c[i] = (cfg[i][11] & h[i]) | (cfg[i][10] & lo[i]);
      p = p | ({3{h[i]}} & cfg[i][5:3]) | ({3{lo[i]}} & cfg[i][2:0]);
      check(chan_scale_select[2*i +: 2], cfg[i][9:8]);
    end
    check(upper_comparator, h);
    check(lower_comparator, lo);
    check(chan_fault_out, c);
    check(pin_fault_route, p);
  endtask : check_outs
  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    defaults();
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 6; i++) begin
        w = 16'(rnd()) & 16'hefff;
        host.xfer(1'b1, `CMD_CFG_FIRST + 8'(i), w, rd);
        cfg[i] = w & `CFG_USED_MASK;
        rdx(`CMD_CFG_FIRST + 8'(i), cfg[i]);
      end
      drive(6'(rnd()), 6'(rnd()));
      check_outs();
    end
    host.xfer(1'b1, `CMD_CFG_FIRST, 16'h1880, rd);
    drive(6'h00, '1);
    // Clear drops hold state left over from the random phase
    host.xfer(1'b1, `CMD_CLEAR, 16'h0000, rd);
    repeat (CLR + 4) @(posedge clk);
    #1;
    check(chan_fault_out[0], 1'b0);
    drive(6'h01, '1);
    drive(6'h00, '1);
    check(chan_fault_out[0], 1'b1);
    host.xfer(1'b1, `CMD_RESTORE, 16'h0000, rd);
    defaults();
    host.xfer(1'b1, `CMD_CLEAR, 16'h0000, rd);
    n = 0;
    for (int k = 0; k < 200; k++) begin
      @(posedge clk);
      #1;
      if (cmd_rsp.busy === 1'b1) n++;
    end
    check(16'(n), 16'(CLR));
    rdx(`CMD_HISTORY, 16'h0000);
    r = 6'(rnd()) | 6'h01;
    l = 6'(rnd()) | 6'h02;
    drive(r, '1);
    drive(0, '1);
    hist = hv(r, 0);
    rdx(`CMD_HISTORY, hist);
    check(alert_latched, 1'b0);
    drive(0, ~l);
    drive(0, '1);
    check(alert_latched, 1'b1);
    @(posedge clk);
    alert_ack <= 1'b1;
    @(posedge clk);
    alert_ack <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(alert_latched, 1'b0);
    rdx(`CMD_HISTORY, hist | hv(0, l));
    host.read_snapshot(rd);
    check(rd, hist);
    host.xfer(1'b1, `CMD_CFG_FIRST + 8'h02, 16'h0889, rd);
    host.xfer(1'b1, `CMD_STORE, 16'h0000, rd);
    host.xfer(1'b1, `CMD_CFG_FIRST + 8'h02, 16'h0489, rd);
    host.xfer(1'b1, `CMD_RESTORE, 16'h0000, rd);
    rdx(`CMD_CFG_FIRST + 8'h02, 16'h0889);
    @(posedge clk);
    manual_reset_input_en <= 2'b01;
    manual_reset_wipes_log <= 2'b01;
    general_input_pin <= 2'b10;
    repeat (6) @(posedge clk);
    general_input_pin <= 2'b11;
    manual_reset_input_en <= 2'b00;
    rdx(`CMD_HISTORY, 16'h0000);
    w = 16'(rnd()) & `PADS_USED_MASK;
    @(posedge clk);
    general_input_pin <= w[10:9];
    general_io_pin <= w[8:6];
    chan_fault_pad <= w[5:0];
    repeat (4) @(posedge clk);
    rdx(`CMD_PADS, w);
    host.xfer(1'b1, `CMD_CLEAR, 16'h0000, rd);
    host.xfer(1'b1, `CMD_STORE, 16'h0000, rd);
    host.read_snapshot(rd);
    check(rd, 16'h0000);
    tally_and_finish();
  end
endmodule : testbench
